/* core/bfs_supervisor.sv */
// Breaker failure supervisor with Avalon-MM register slave
//
// Summary of operation
// - Any enabled trigger starts the supervision timer, whatever scheme is chosen.
// - Current scheme: failure if current stays at or above threshold until expiry.
// - Position scheme: failure if position never shows open before expiry.
// - Combined scheme: failure only if current high and position not open.
// - A global scheme field selects current, position or combined detection.
// - Failure trip drives a relay output and is readable over the bus.
// - Timer keeps running after the trigger drops.
// - Timer stops as soon as opening is seen under the selected scheme.
// - After opening with triggers active, stay rejected until all enabled triggers drop.
// - A lockout latches with the trip and holds until acknowledged.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module bfs_supervisor
	import bfs_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  sys_rst_i,
	// Avalon-MM slave
	input  wire bfs_pkg::bfs_avm_req_t avs_req_i,
	output logic [31:0]                avs_readdata_o,
	output logic                       avs_waitrequest_o,
	// Protection inputs
	input  wire logic [3:0]            trigger_i,
	input  wire bfs_pkg::bfs_breaker_t breaker_i,
	// Protection outputs
	output logic                       failure_trip_o,
	output logic                       lockout_o,
	output logic                       irq_o
);
	typedef struct packed
	{
		bfs_state_t        state;
		logic [1:0]        scheme;
		logic [3:0]        trig_en;
		logic [15:0]       thresh;
		logic [31:0]       delay;
		logic              trip;
		logic              lockout;
		logic [BFS_EV_N-1:0] irq_st;
		logic [BFS_EV_N-1:0] irq_en;
		logic              irq;
		logic              ack_done;
		logic [31:0]       rdata;
	} bfs_core_state_t;

	bfs_core_state_t st_reg;
	bfs_core_state_t st_next;

	logic tmr_load;
	logic tmr_stop;
	logic tmr_running;
	logic tmr_expired;
	logic triggered;
	logic opened;
	logic [BFS_EV_N-1:0] ev;
	logic bus_take;
	logic bus_commit;

	// Opening test for a given scheme
	function automatic logic breaker_opened(input logic [1:0] sch, input bfs_breaker_t b,
		input logic [15:0] th);
		logic cur_low;
		logic pos_open;
		cur_low  = (b.current < th);
		pos_open = b.pos_open && !b.pos_closed;
		unique case (sch)
			BFS_SCH_CURRENT:  breaker_opened = cur_low;
			BFS_SCH_POSITION: breaker_opened = pos_open;
			BFS_SCH_COMBINED: breaker_opened = cur_low || pos_open;
			default:          breaker_opened = cur_low;
		endcase
	endfunction : breaker_opened

	assign triggered = |(trigger_i & st_reg.trig_en);
	assign opened    = breaker_opened(st_reg.scheme, breaker_i, st_reg.thresh);
	assign tmr_load  = (st_reg.state == BFS_ST_STANDBY) && triggered;
	assign tmr_stop  = (st_reg.state == BFS_ST_RUNNING) && opened;

	// Access taken while waitrequest high, committed when it drops
	assign bus_take   = (avs_req_i.read || avs_req_i.write) && !st_reg.ack_done;
	assign bus_commit = avs_req_i.write && st_reg.ack_done;

	// Supervision timer
	bfs_timer u_timer
	(
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (tmr_load),
		.stop_i    (tmr_stop),
		.delay_i   (st_reg.delay),
		.running_o (tmr_running),
		.expired_o (tmr_expired)
	);

	always_comb
	begin
		st_next          = st_reg;
		st_next.ack_done = 1'b0;
		ev               = '0;

		unique case (st_reg.state)
			BFS_ST_STANDBY:
			begin
				if (triggered)
				begin
					st_next.state     = BFS_ST_RUNNING;
					ev[BFS_EV_START]  = 1'b1;
				end
			end
			BFS_ST_RUNNING:
			begin
				// Trigger loss ignored while timing
				if (opened)
				begin
					st_next.state     = BFS_ST_REJECTED;
					ev[BFS_EV_REJECT] = 1'b1;
				end
				else if (tmr_expired)
				begin
					st_next.state     = BFS_ST_FAILED;
					st_next.trip      = 1'b1;
					st_next.lockout   = 1'b1;
					ev[BFS_EV_FAIL]   = 1'b1;
				end
			end
			BFS_ST_REJECTED:
			begin
				if (!triggered)
				begin
					st_next.state = BFS_ST_STANDBY;
				end
			end
			BFS_ST_FAILED:
			begin
				// Trip held while triggers persist and breaker still not open
				if (!triggered || opened)
				begin
					st_next.trip  = 1'b0;
					st_next.state = triggered ? BFS_ST_REJECTED : BFS_ST_STANDBY;
				end
			end
		endcase

		// Unmapped offsets read as zero and ignore writes
		// One wait cycle; read data registered for the answer cycle
		if (bus_take)
		begin
			st_next.ack_done = 1'b1;
			st_next.rdata    = 32'h0000_0000;
			if (avs_req_i.read)
			begin
				unique case (avs_req_i.address)
					BFS_OFS_CTRL:   st_next.rdata = {24'h0, st_reg.trig_en, 2'h0, st_reg.scheme};
					BFS_OFS_THRESH: st_next.rdata = {16'h0, st_reg.thresh};
					BFS_OFS_DELAY:  st_next.rdata = st_reg.delay;
					BFS_OFS_STAT:   st_next.rdata = {26'h0, tmr_running, st_reg.lockout,
						st_reg.trip, 1'b0, st_reg.state};
					BFS_OFS_IRQ_ST: st_next.rdata = {29'h0, st_reg.irq_st};
					BFS_OFS_IRQ_EN: st_next.rdata = {29'h0, st_reg.irq_en};
					default:        st_next.rdata = 32'h0000_0000;
				endcase
			end
		end

		// Write lands on the edge that completes the transfer
		if (bus_commit)
		begin
			unique case (avs_req_i.address)
				BFS_OFS_CTRL:
				begin
					st_next.scheme  = avs_req_i.writedata[BFS_CTRL_SCHEME_LSB +: 2];
					st_next.trig_en = avs_req_i.writedata[BFS_CTRL_TRIGEN_LSB +: 4];
				end
				BFS_OFS_THRESH: st_next.thresh = avs_req_i.writedata[15:0];
				BFS_OFS_DELAY:  st_next.delay  = avs_req_i.writedata;
				BFS_OFS_IRQ_EN: st_next.irq_en = avs_req_i.writedata[BFS_EV_N-1:0];
				BFS_OFS_IRQ_CL:
					st_next.irq_st = st_reg.irq_st & ~avs_req_i.writedata[BFS_EV_N-1:0];
				BFS_OFS_ACK:
					// A failure in the same cycle keeps the lockout
					if (avs_req_i.writedata[BFS_ACK_LOCK_BIT] && !ev[BFS_EV_FAIL])
					begin
						st_next.lockout = 1'b0;
					end
				default: ;
			endcase
		end

		// Set wins over clear
		st_next.irq_st = st_next.irq_st | ev;
		st_next.irq    = |(st_next.irq_st & st_next.irq_en);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			// Configuration fields come up at their defaults
			st_reg         <= '0;
			st_reg.state   <= BFS_ST_STANDBY;
			st_reg.scheme  <= BFS_SCHEME_RST;
			st_reg.trig_en <= BFS_TRIGEN_RST;
			st_reg.thresh  <= BFS_THRESH_RST;
			st_reg.delay   <= BFS_DELAY_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign avs_readdata_o    = st_reg.rdata;
	assign avs_waitrequest_o = !st_reg.ack_done;
	assign failure_trip_o    = st_reg.trip;
	assign lockout_o         = st_reg.lockout;
	assign irq_o             = st_reg.irq;

endmodule : bfs_supervisor

/* core/bfs_pkg.sv */
// Package of constants, types and register map for the breaker failure supervisor
package bfs_pkg;

	// Register word offsets
	localparam logic [3:0]  BFS_OFS_CTRL   = 4'h0;
	localparam logic [3:0]  BFS_OFS_THRESH = 4'h1;
	localparam logic [3:0]  BFS_OFS_DELAY  = 4'h2;
	localparam logic [3:0]  BFS_OFS_STAT   = 4'h3;
	localparam logic [3:0]  BFS_OFS_IRQ_ST = 4'h4;
	localparam logic [3:0]  BFS_OFS_IRQ_EN = 4'h5;
	localparam logic [3:0]  BFS_OFS_IRQ_CL = 4'h6;
	localparam logic [3:0]  BFS_OFS_ACK    = 4'h7;

	// Field positions
	localparam int          BFS_CTRL_SCHEME_LSB = 0;
	localparam int          BFS_CTRL_TRIGEN_LSB = 4;
	localparam int          BFS_ACK_LOCK_BIT    = 0;

	// Reset values
	localparam logic [1:0]  BFS_SCHEME_RST = 2'h0;
	localparam logic [3:0]  BFS_TRIGEN_RST = 4'hf;
	localparam logic [15:0] BFS_THRESH_RST = 16'h0100;
	localparam logic [31:0] BFS_DELAY_RST  = 32'h0000_c350;

	// Interrupt event bits
	localparam int          BFS_EV_START   = 0;
	localparam int          BFS_EV_FAIL    = 1;
	localparam int          BFS_EV_REJECT  = 2;
	localparam int          BFS_EV_N       = 3;

	typedef enum logic [1:0]
	{
		BFS_SCH_CURRENT  = 2'b00,
		BFS_SCH_POSITION = 2'b01,
		BFS_SCH_COMBINED = 2'b10
	} bfs_scheme_t;

	typedef enum logic [1:0]
	{
		BFS_ST_STANDBY  = 2'b00,
		BFS_ST_RUNNING  = 2'b01,
		BFS_ST_REJECTED = 2'b10,
		BFS_ST_FAILED   = 2'b11
	} bfs_state_t;

	// Avalon-MM slave request
	typedef struct packed
	{
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} bfs_avm_req_t;

	// Breaker measurement and position inputs
	typedef struct packed
	{
		logic [15:0] current;
		logic        pos_open;
		logic        pos_closed;
	} bfs_breaker_t;

endpackage : bfs_pkg

/* core/bfs_timer.sv */
// Supervision down-counter loaded with the configured delay
`timescale 1ns/1ps
module bfs_timer
(
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// Control
	input  wire logic        load_i,
	input  wire logic        stop_i,
	input  wire logic [31:0] delay_i,
	// Status
	output logic             running_o,
	output logic             expired_o
);
	typedef struct packed
	{
		logic [31:0] count;
		logic        running;
		logic        expired;
	} bfs_tmr_state_t;

	bfs_tmr_state_t st_reg;
	bfs_tmr_state_t st_next;

	always_comb
	begin
		st_next         = st_reg;
		st_next.expired = 1'b0;
		if (load_i)
		begin
			st_next.count   = delay_i;
			st_next.running = 1'b1;
		end
		else if (stop_i)
		begin
			st_next.running = 1'b0;
		end
		else if (st_reg.running)
		begin
			if (st_reg.count <= 32'h0000_0001)
			begin
				st_next.count   = 32'h0000_0000;
				st_next.running = 1'b0;
				st_next.expired = 1'b1;
			end
			else
			begin
				st_next.count = st_reg.count - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign running_o = st_reg.running;
	assign expired_o = st_reg.expired;

endmodule : bfs_timer

/* verif/bfs_supervisor_props.sv */
// Port assertions for the breaker failure supervisor
`timescale 1ns/1ps
module bfs_supervisor_chk
	import bfs_pkg::*;
(
	// Watched ports
	input  wire logic                  sys_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire bfs_pkg::bfs_avm_req_t avs_req_i,
	input  wire logic [31:0]           avs_readdata_o,
	input  wire logic                  avs_waitrequest_o,
	input  wire logic [3:0]            trigger_i,
	input  wire bfs_pkg::bfs_breaker_t breaker_i,
	input  wire logic                  failure_trip_o,
	input  wire logic                  lockout_o,
	input  wire logic                  irq_o
);
	logic ack_w;
	assign ack_w = avs_req_i.write && avs_req_i.address == BFS_OFS_ACK && avs_req_i.writedata[0];
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_lock_trip; $rose(failure_trip_o) |-> lockout_o; endproperty
	a_lock_trip: assert property (p_lock_trip) else $error("no lockout at trip");
	property p_lock_rise; $rose(lockout_o) |-> $rose(failure_trip_o); endproperty
	a_lock_rise: assert property (p_lock_rise) else $error("lockout without trip");
	property p_lock_hold; lockout_o && !ack_w |=> lockout_o; endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lockout lost");
	property p_lock_clr; ack_w && !avs_waitrequest_o |=> !lockout_o || failure_trip_o; endproperty
	a_lock_clr: assert property (p_lock_clr) else $error("lockout not cleared");
	property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer too long");
	property p_answer; (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_unmapped; avs_req_i.read && avs_req_i.address[3] && !avs_waitrequest_o |->
		avs_readdata_o == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_trip_hold; failure_trip_o && trigger_i != 4'h0 && breaker_i.current == 16'hffff &&
		breaker_i.pos_closed |=> failure_trip_o; endproperty
	a_trip_hold: assert property (p_trip_hold) else $error("trip dropped");
	c_trip: cover property ($rose(failure_trip_o));
	c_ack: cover property ($fell(lockout_o));
	c_irq: cover property ($rose(irq_o));
endmodule : bfs_supervisor_chk
bind bfs_supervisor bfs_supervisor_chk u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.trigger_i(trigger_i), .breaker_i(breaker_i), .failure_trip_o(failure_trip_o),
	.lockout_o(lockout_o), .irq_o(irq_o));

/* verif/bfs_breaker_model.sv */
// Breaker model whose contacts travel a few cycles after an open command
`timescale 1ns/1ps
module bfs_breaker_model
	import bfs_pkg::*;
(
	// Clock and commands
	input  wire logic             sys_clk_i,
	input  wire logic             cur_low_i,
	input  wire logic             open_i,
	// Measured breaker
	output bfs_pkg::bfs_breaker_t breaker_o
);
	logic [1:0] travel_reg;
	// In transit neither position indicator is shown
	always_ff @(posedge sys_clk_i)
		travel_reg <= !open_i ? 2'h0 : (travel_reg == 2'h3 ? 2'h3 : travel_reg + 2'h1);
	assign breaker_o.current    = cur_low_i ? 16'h0010 : 16'hffff;
	assign breaker_o.pos_open   = travel_reg == 2'h3;
	assign breaker_o.pos_closed = travel_reg == 2'h0;
endmodule : bfs_breaker_model

/* verif/bfs_supervisor_test.sv */
// Self-checking bench for the breaker failure supervisor
`timescale 1ns/1ps
module bfs_supervisor_test;
	import bfs_pkg::*;
	localparam int DLY = 10;
	logic         sys_clk_i = 1'b0;
	logic         sys_rst_i = 1'b1;
	bfs_avm_req_t req       = '0;
	logic [3:0]   trig      = 4'h0;
	logic         cur_low   = 1'b0;
	logic         open_cmd  = 1'b0;
	logic [31:0]  rdata;
	logic         wrq;
	logic         trip;
	logic         lock;
	logic         irq;
	bfs_breaker_t brk;
	int           errors    = 0;
	int           checks    = 0;
	bfs_supervisor DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .avs_req_i(req),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wrq), .trigger_i(trig), .breaker_i(brk),
		.failure_trip_o(trip), .lockout_o(lock), .irq_o(irq));
	bfs_breaker_model u_brk (.sys_clk_i(sys_clk_i), .cur_low_i(cur_low), .open_i(open_cmd),
		.breaker_o(brk));
	initial forever #10 sys_clk_i = ~sys_clk_i;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task bchk(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : bchk
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc
	task bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		req <= '{a, !w, w, d};
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (wrq !== 1'b0 && n < 100);
		q = rdata;
		if (wrq !== 1'b0)
		begin
			errors++;
			$display("unexpected %0t no bus answer", $time);
		end
		req <= '0;
	endtask : bus
	task wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr
	task rdchk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(q, exp);
	endtask : rdchk
	task t_reset;
		rdchk(BFS_OFS_CTRL, {24'h0, BFS_TRIGEN_RST, 2'h0, BFS_SCHEME_RST});
		rdchk(BFS_OFS_THRESH, {16'h0, BFS_THRESH_RST});
		rdchk(BFS_OFS_DELAY, BFS_DELAY_RST);
		rdchk(4'h9, 32'h0);
		wr(BFS_OFS_DELAY, 32'(DLY));
	endtask : t_reset
	task t_fail(input logic [1:0] s, input logic cl, input logic op, input int h);
		int n;
		wr(BFS_OFS_CTRL, {24'h0, 4'hf, 2'h0, s});
		cur_low <= cl;
		open_cmd <= op;
		trig <= 4'h2;
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			n++;
			if (n == h)
				trig <= 4'h0;
		end
		while (trip !== 1'b1 && n < 60);
		trig <= 4'h0;
		bchk(trip, 1'b1);
		bchk(n >= DLY && n <= DLY + 4, 1'b1);
		bchk(lock, 1'b1);
		cyc(3);
		bchk(lock, 1'b1);
		wr(BFS_OFS_ACK, 32'h1);
		cyc(1);
		bchk(lock, 1'b0);
		cur_low <= 1'b0;
		open_cmd <= 1'b0;
	endtask : t_fail
	task t_reject(input logic [1:0] s, input logic cl, input logic op);
		wr(BFS_OFS_CTRL, {24'h0, 4'hf, 2'h0, s});
		trig <= 4'h1;
		cyc(2);
		cur_low <= cl;
		open_cmd <= op;
		cyc(DLY + 6);
		bchk(trip, 1'b0);
		rdchk(BFS_OFS_STAT, 32'h2);
		trig <= 4'h0;
		cyc(2);
		rdchk(BFS_OFS_STAT, 32'h0);
		cur_low <= 1'b0;
		open_cmd <= 1'b0;
	endtask : t_reject
	task t_irq;
		wr(BFS_OFS_IRQ_CL, 32'h7);
		t_fail(BFS_SCH_POSITION, 1'b1, 1'b0, 1);
		rdchk(BFS_OFS_IRQ_ST, 32'h3);
		wr(BFS_OFS_IRQ_EN, 32'h2);
		cyc(2);
		bchk(irq, 1'b1);
		wr(BFS_OFS_IRQ_EN, 32'h0);
		cyc(2);
		bchk(irq, 1'b0);
		wr(BFS_OFS_IRQ_CL, 32'h2);
		rdchk(BFS_OFS_IRQ_ST, 32'h1);
	endtask : t_irq
	task t_gate;
		wr(BFS_OFS_CTRL, {24'h0, 4'hd, 2'h0, BFS_SCH_CURRENT});
		trig <= 4'h2;
		cyc(DLY + 6);
		bchk(trip, 1'b0);
		rdchk(BFS_OFS_STAT, 32'h0);
		trig <= 4'h0;
	endtask : t_gate
	task end_of_test;
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	initial
	begin
		cyc(2);
		sys_rst_i <= 1'b0;
		t_reset;
		t_fail(BFS_SCH_CURRENT, 1'b0, 1'b1, 1);
		t_fail(BFS_SCH_COMBINED, 1'b0, 1'b0, 60);
		t_irq;
		t_reject(BFS_SCH_CURRENT, 1'b1, 1'b0);
		rdchk(BFS_OFS_IRQ_ST, 32'h5);
		t_reject(BFS_SCH_POSITION, 1'b0, 1'b1);
		t_reject(BFS_SCH_COMBINED, 1'b0, 1'b1);
		t_reject(BFS_SCH_COMBINED, 1'b1, 1'b0);
		t_fail(2'h3, 1'b0, 1'b1, 1);
		wr(BFS_OFS_THRESH, 32'h0000_0008);
		rdchk(BFS_OFS_THRESH, 32'h0000_0008);
		t_fail(BFS_SCH_CURRENT, 1'b1, 1'b0, 1);
		t_gate;
		end_of_test;
	end
	initial
	begin
		#100000;
		errors++;
		end_of_test;
	end
endmodule : bfs_supervisor_test
